// File: rtl/scts_ctrl.sv
/*
 * scaler task event handler with register sets a/b, status byte and
 * input source selection, reached by byte accesses at subaddresses.
 * assumes the serial bus agent outside issues one-cycle rd/wr strobes.
 */
`default_nettype none

module scts_ctrl
    import scts_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // register access by subaddress
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // pins and internal flags
    input wire logic expansion_port_disable_pin_i,
    input wire logic image_port_disable_pin_i,
    input wire logic fifo_almost_full_flag_i,
    input wire logic fifo_overflow_flag_i,
    input wire logic formatter_error_flag_i,
    input wire logic input_field_id_flag_i,
    input wire logic expansion_request_mode_i,
    // scaler timing
    input wire logic vsync_i,
    input wire logic task_done_i,
    input wire logic line_start_i,
    input wire logic v_int_i,
    input wire logic v_gate_int_i,
    // handler outputs
    output logic task_start_o,
    output logic task_running_o,
    output logic active_set_o,
    output logic output_field_id_flag_o,
    output logic sav_eav_bit7_o,
    output logic task_flag_o,
    output logic sav_f_bit_o,
    output logic sav_v_bit_o,
    output logic image_vertical_gate_pin_o,
    // input source control
    output logic [1:0] scaler_source_select_o,
    output logic source_request_react_o
);

    function automatic logic trig_hit(input logic [1:0] code,
                                      input logic vs, input logic fid);
        case (code)
            SCTS_TRIG_IMM: trig_hit = 1'b1;
            SCTS_TRIG_VS: trig_hit = vs;
            SCTS_TRIG_F0: trig_hit = vs && !fid;
            SCTS_TRIG_F1: trig_hit = vs && fid;
            default: trig_hit = 1'b0;
        endcase
    endfunction : trig_hit

    scts_task_t task_a_r, task_b_r, act_task_r, sel_task;
    scts_cfg_t cfg_a_r, cfg_b_r, act_cfg_r;
    scts_state_t state_r;
    scts_status_t status;
    logic prog_r;
    logic set_r;
    logic repeated_r;
    logic task_flag_r;
    logic [2:0] skip_r;
    logic hit;

    // register sets a and b, identical layout
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            task_a_r <= scts_task_t'(SCTS_TASK_RST);
            task_b_r <= scts_task_t'(SCTS_TASK_RST);
            cfg_a_r <= scts_cfg_t'(SCTS_CFG_RST);
            cfg_b_r <= scts_cfg_t'(SCTS_CFG_RST);
        end else if (ce_i && reg_wr_i) begin
            case (reg_addr_i)
                SCTS_ADDR_TASK_A: task_a_r <= scts_task_t'(reg_wdata_i);
                SCTS_ADDR_CFG_A: cfg_a_r <= scts_cfg_t'(reg_wdata_i);
                SCTS_ADDR_TASK_B: task_b_r <= scts_task_t'(reg_wdata_i);
                SCTS_ADDR_CFG_B: cfg_b_r <= scts_cfg_t'(reg_wdata_i);
                default: ;
            endcase
        end
    end

    // programmed marker
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prog_r <= SCTS_PROG_RST;
        end else if (ce_i && reg_wr_i && reg_addr_i == SCTS_ADDR_POWER) begin
            prog_r <= reg_wdata_i[SCTS_PROG_BIT];
        end
    end

    // live status byte
    always_comb begin
        status.expansion_port_disable_pin = expansion_port_disable_pin_i;
        status.image_port_disable_pin = image_port_disable_pin_i;
        status.fifo_almost_full_flag = fifo_almost_full_flag_i;
        status.fifo_overflow_flag = fifo_overflow_flag_i;
        status.programmed_copy_flag = prog_r;
        status.formatter_error_flag = formatter_error_flag_i;
        status.input_field_id_flag = input_field_id_flag_i;
        status.output_field_id_flag = output_field_id_flag_o;
    end

    // read port, status sampled at the read strobe
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    SCTS_ADDR_STATUS: reg_rdata_o <= status;
                    SCTS_ADDR_POWER:
                        reg_rdata_o <= 8'(prog_r) << SCTS_PROG_BIT;
                    SCTS_ADDR_TASK_A: reg_rdata_o <= task_a_r;
                    SCTS_ADDR_CFG_A: reg_rdata_o <= cfg_a_r;
                    SCTS_ADDR_TASK_B: reg_rdata_o <= task_b_r;
                    SCTS_ADDR_CFG_B: reg_rdata_o <= cfg_b_r;
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // the waiting set is read live, the running set from its copy
    always_comb begin
        sel_task = set_r ? task_b_r : task_a_r;
        hit = trig_hit(sel_task.handler_trigger_code, vsync_i,
                       input_field_id_flag_i);
    end

    // event handler
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= SCTS_ST_WAIT;
            set_r <= 1'b0;
            repeated_r <= 1'b0;
            task_flag_r <= 1'b0;
            skip_r <= 3'h0;
            task_start_o <= 1'b0;
            act_task_r <= scts_task_t'(SCTS_TASK_RST);
            act_cfg_r <= scts_cfg_t'(SCTS_CFG_RST);
        end else if (ce_i) begin
            task_start_o <= 1'b0;
            case (state_r)
                SCTS_ST_WAIT: begin
                    if (hit) begin
                        act_task_r <= sel_task;
                        act_cfg_r <= set_r ? cfg_b_r : cfg_a_r;
                        skip_r <= sel_task.field_skip_count;
                        if (sel_task.field_skip_count == 3'h0) begin
                            state_r <= SCTS_ST_RUN;
                            task_start_o <= 1'b1;
                            task_flag_r <= !task_flag_r;
                        end else begin
                            state_r <= SCTS_ST_SKIP;
                        end
                    end
                end
                SCTS_ST_SKIP: begin
                    if (vsync_i) begin
                        skip_r <= skip_r - 3'h1;
                        if (skip_r == 3'h1) begin
                            state_r <= SCTS_ST_RUN;
                            task_start_o <= 1'b1;
                            task_flag_r <= !task_flag_r;
                        end
                    end
                end
                SCTS_ST_RUN: begin
                    if (task_done_i) begin
                        if (act_task_r.repeat_task_bit && !repeated_r) begin
                            repeated_r <= 1'b1;
                            task_start_o <= 1'b1;
                            task_flag_r <= !task_flag_r;
                        end else begin
                            repeated_r <= 1'b0;
                            set_r <= !set_r;
                            state_r <= SCTS_ST_WAIT;
                        end
                    end
                end
                default: state_r <= SCTS_ST_WAIT;
            endcase
        end
    end

    // field id, sav bit 7 and task flag outputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            output_field_id_flag_o <= 1'b0;
            sav_eav_bit7_o <= 1'b1;
            task_flag_o <= 1'b1;
        end else if (ce_i) begin
            output_field_id_flag_o <= act_task_r.output_field_id_select ?
                task_flag_r : input_field_id_flag_i;
            sav_eav_bit7_o <= !act_task_r.sav_eav_polarity_bit;
            task_flag_o <= !act_task_r.sav_eav_polarity_bit;
        end
    end

    // input source selection
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            scaler_source_select_o <= 2'h0;
            source_request_react_o <= 1'b0;
        end else if (ce_i) begin
            scaler_source_select_o <= act_cfg_r.scaler_source_select;
            source_request_react_o <= expansion_request_mode_i &&
                !act_cfg_r.request_enable_bit;
        end
    end

    assign task_running_o = (state_r == SCTS_ST_RUN);
    assign active_set_o = set_r;

    scts_sav_gen u_sav_gen (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .cfg_i(act_cfg_r),
        .f_int_i(output_field_id_flag_o),
        .v_int_i(v_int_i),
        .v_gate_int_i(v_gate_int_i),
        .line_start_i(line_start_i),
        .sav_f_bit_o(sav_f_bit_o),
        .sav_v_bit_o(sav_v_bit_o),
        .image_vertical_gate_pin_o(image_vertical_gate_pin_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_status_read;
        ce_i && reg_rd_i && reg_addr_i == SCTS_ADDR_STATUS;
    endsequence

    a_expansion_port_disable_pin_status: assert property (
        s_status_read |=> reg_rdata_o[7] == $past(expansion_port_disable_pin_i))
        else $error("status bit 7 not the expansion pin");

    a_image_port_disable_pin_status: assert property (
        s_status_read |=> reg_rdata_o[6] == $past(image_port_disable_pin_i))
        else $error("status bit 6 not the image pin");

    a_fifo_status: assert property (
        s_status_read |=> reg_rdata_o[5:4] ==
            {$past(fifo_almost_full_flag_i), $past(fifo_overflow_flag_i)})
        else $error("fifo status bits wrong");

    a_prog_copy: assert property (
        s_status_read
        |=> reg_rdata_o[3] == $past(prog_r))
        else $error("programmed copy does not follow marker");

    a_err_fid: assert property (
        s_status_read |=> reg_rdata_o[2:1] ==
            {$past(formatter_error_flag_i), $past(input_field_id_flag_i)})
        else $error("error or input field id status wrong");

    a_ofid_status: assert property (
        s_status_read |=> reg_rdata_o[0] == $past(output_field_id_flag_o))
        else $error("output field id status wrong");

    a_status_ro: assert property (
        ce_i && reg_wr_i && reg_addr_i == SCTS_ADDR_STATUS
        |=> $stable(task_a_r) && $stable(cfg_a_r) && $stable(prog_r))
        else $error("write to status changed state");

    a_ofid_follow: assert property (
        ce_i && !act_task_r.output_field_id_select
        |=> output_field_id_flag_o == $past(input_field_id_flag_i))
        else $error("output field id not following input");

    a_sav_polarity: assert property (
        ce_i |=> sav_eav_bit7_o == !$past(act_task_r.sav_eav_polarity_bit))
        else $error("sav bit 7 polarity wrong");

    a_skip_direct: assert property (
        ce_i && state_r == SCTS_ST_WAIT && hit &&
        sel_task.field_skip_count == 3'h0
        |=> state_r == SCTS_ST_RUN && task_start_o)
        else $error("zero skip did not start task");

    a_trig_wait: assert property (
        ce_i && state_r == SCTS_ST_WAIT &&
        sel_task.handler_trigger_code != SCTS_TRIG_IMM && !vsync_i
        |=> state_r == SCTS_ST_WAIT)
        else $error("handler started without vertical sync");

    sequence s_first_done;
        ce_i && state_r == SCTS_ST_RUN && task_done_i &&
        act_task_r.repeat_task_bit && !repeated_r;
    endsequence

    a_repeat_once: assert property (
        s_first_done |=> state_r == SCTS_ST_RUN && task_start_o &&
            $stable(set_r))
        else $error("task not repeated once");

    a_prog_reset: assert property (
        @(posedge clk_i) disable iff (1'b0)
        srst_i |=> !prog_r)
        else $error("programmed marker not cleared by reset");

    a_req_react: assert property (
        ce_i |=> source_request_react_o == ($past(expansion_request_mode_i)
            && !$past(act_cfg_r.request_enable_bit)))
        else $error("request reaction wrong");

endmodule : scts_ctrl

`default_nettype wire

// File: shared/scts_pkg.sv
/*
 * package of the scaler task/status control block: register subaddresses,
 * reset values, handler states and the packed register layouts.
 * assumes a host-side bus agent that presents byte accesses by subaddress.
 */
// Overview of operation
// - status bit 7 shows expansion port pin
// - status bit 6 shows image port pin
// - bits 5/4 show fifo almost-full, overflow
// - status bit 3 copies programmed marker bit
// - status bit 2 shows formatter error flag
// - bit 1 input field id, bit 0 output
// - status read-only, sampled at read moment
// - output field id: input id or task flag
// - polarity bit sets sav bit7, task flag
// - skip count skips fields before task runs
// - trigger code picks handler start condition
// - repeat bit reruns active task once
// - request enable 0 reacts to data requests
// - two-bit source select picks scaler input
// - hold bit updates f/v at line start
// - vertical polarity inverts v bit, gate
// - two identical register sets a and b
// - programmed marker clears on reset
`default_nettype none

package scts_pkg;

    // register subaddresses
    localparam logic [7:0] SCTS_ADDR_STATUS = 8'h8f;
    localparam logic [7:0] SCTS_ADDR_POWER = 8'h88;
    localparam logic [7:0] SCTS_ADDR_TASK_A = 8'h90;
    localparam logic [7:0] SCTS_ADDR_CFG_A = 8'h91;
    localparam logic [7:0] SCTS_ADDR_TASK_B = 8'hc0;
    localparam logic [7:0] SCTS_ADDR_CFG_B = 8'hc1;

    // field position of the programmed marker in the power register
    localparam int SCTS_PROG_BIT = 4;

    // reset values
    localparam logic [7:0] SCTS_TASK_RST = 8'h00;
    localparam logic [7:0] SCTS_CFG_RST = 8'h00;
    localparam logic SCTS_PROG_RST = 1'b0;

    // trigger codes
    localparam logic [1:0] SCTS_TRIG_IMM = 2'h0;
    localparam logic [1:0] SCTS_TRIG_VS = 2'h1;
    localparam logic [1:0] SCTS_TRIG_F0 = 2'h2;
    localparam logic [1:0] SCTS_TRIG_F1 = 2'h3;

    typedef enum logic [2:0] {
        SCTS_ST_WAIT = 3'h1,
        SCTS_ST_SKIP = 3'h2,
        SCTS_ST_RUN = 3'h4
    } scts_state_t;

    // task handling register, bits 7..0
    typedef struct packed {
        logic sav_eav_polarity_bit;
        logic output_field_id_select;
        logic [2:0] field_skip_count;
        logic repeat_task_bit;
        logic [1:0] handler_trigger_code;
    } scts_task_t;

    // scaler input configuration register, bits 7..0
    typedef struct packed {
        logic vertical_polarity_bit;
        logic field_vertical_hold_bit;
        logic [1:0] scaler_source_select;
        logic request_enable_bit;
        logic [2:0] format_bits;
    } scts_cfg_t;

    // status byte, bits 7..0
    typedef struct packed {
        logic expansion_port_disable_pin;
        logic image_port_disable_pin;
        logic fifo_almost_full_flag;
        logic fifo_overflow_flag;
        logic programmed_copy_flag;
        logic formatter_error_flag;
        logic input_field_id_flag;
        logic output_field_id_flag;
    } scts_status_t;

endpackage : scts_pkg

`default_nettype wire

// File: rtl/scts_sav_gen.sv
/*
 * sav/eav f and v bit generation and image port vertical gate polarity.
 * assumes f, v and gate inputs come from the scaler output timing.
 */
`default_nettype none

module scts_sav_gen
    import scts_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // configuration of the active set
    input wire scts_cfg_t cfg_i,
    // internal timing
    input wire logic f_int_i,
    input wire logic v_int_i,
    input wire logic v_gate_int_i,
    input wire logic line_start_i,
    // generated bits
    output logic sav_f_bit_o,
    output logic sav_v_bit_o,
    output logic image_vertical_gate_pin_o
);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sav_f_bit_o <= 1'b0;
            sav_v_bit_o <= 1'b0;
        end else if (ce_i) begin
            if (!cfg_i.field_vertical_hold_bit || line_start_i) begin
                sav_f_bit_o <= f_int_i;
                sav_v_bit_o <= v_int_i ^ cfg_i.vertical_polarity_bit;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            image_vertical_gate_pin_o <= 1'b0;
        end else if (ce_i) begin
            image_vertical_gate_pin_o <= v_gate_int_i ^
                cfg_i.vertical_polarity_bit;
        end
    end

    a_fv_hold: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && cfg_i.field_vertical_hold_bit && !line_start_i
        |=> $stable(sav_f_bit_o) && $stable(sav_v_bit_o))
        else $error("f/v bits changed outside line start");

    a_vgate_inv: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i |=> image_vertical_gate_pin_o ==
            ($past(v_gate_int_i) ^ $past(cfg_i.vertical_polarity_bit)))
        else $error("vertical gate polarity wrong");

endmodule : scts_sav_gen

`default_nettype wire

// File: tb/scts_host.sv
/*
 * host model: byte writes and reads of the control block by subaddress.
 * assumes the block takes one-cycle strobes and answers reads one cycle on.
 */
`default_nettype none

module scts_host
    import scts_pkg::*;
(
    // clock
    input wire logic clk_i,
    // access request
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    // read answer
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= v;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~v;
    endtask : wr

    // no answer in the valid cycle gives an unknown byte
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        #1;
        v = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
    endtask : rd
endmodule : scts_host

`default_nettype wire

// File: tb/scaler_task_status_control_test.sv
/*
 * bench of the scaler task/status control block: status, register sets,
 * event handler and source outputs. assumes scts_host drives the port.
 */
`default_nettype none

module scaler_task_status_control_test
    import scts_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] flg = 8'h00;
    logic mode = 1'b0;
    logic vs = 1'b0;
    logic done = 1'b0;
    logic ls = 1'b0;
    logic vi = 1'b0;
    logic vg = 1'b0;
    wire logic [7:0] addr, wdat, rdat;
    wire logic wr, rd, rv;
    logic start, run, aset, ofid, b7, tfl, fb, vb, gate, react;
    logic [1:0] src;
    logic [7:0] d, e, starts, es;
    logic [7:0] ra [4] = '{SCTS_ADDR_TASK_A, SCTS_ADDR_CFG_A,
        SCTS_ADDR_TASK_B, SCTS_ADDR_CFG_B};
    int err_count = 0;
    int n_compared = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    scts_host scts_host_inst (.clk_i(clk), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_wdata_o(wdat), .reg_rd_o(rd),
        .reg_rdata_i(rdat), .reg_rvalid_i(rv));

    scts_ctrl scts_ctrl_inst (.clk_i(clk), .srst_i(srst), .ce_i(ce),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdat),
        .reg_rd_i(rd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
        .expansion_port_disable_pin_i(flg[7]),
        .image_port_disable_pin_i(flg[6]),
        .fifo_almost_full_flag_i(flg[5]), .fifo_overflow_flag_i(flg[4]),
        .formatter_error_flag_i(flg[2]), .input_field_id_flag_i(flg[1]),
        .expansion_request_mode_i(mode), .vsync_i(vs),
        .task_done_i(done), .line_start_i(ls), .v_int_i(vi),
        .v_gate_int_i(vg), .task_start_o(start), .task_running_o(run),
        .active_set_o(aset), .output_field_id_flag_o(ofid),
        .sav_eav_bit7_o(b7), .task_flag_o(tfl), .sav_f_bit_o(fb),
        .sav_v_bit_o(vb), .image_vertical_gate_pin_o(gate),
        .scaler_source_select_o(src), .source_request_react_o(react));

    // counts task start pulses
    always @(posedge clk) begin
        if (srst) begin
            starts <= 8'h00;
        end else if (start === 1'b1) begin
            starts <= starts + 8'h01;
        end
    end

    task automatic check(input string n, input logic [7:0] s,
        input logic [7:0] x);
        n_compared++;
        if (s !== x) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : check

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic w(input logic [7:0] a, input logic [7:0] v);
        scts_host_inst.wr(a, v);
    endtask : w

    task automatic rc(input string n, input logic [7:0] a,
        input logic [7:0] x);
        scts_host_inst.rd(a, d);
        check(n, d, x);
    endtask : rc

    // k: 0 task done, 1 vsync with field id f, 2 line start
    task automatic pulse(input int k, input logic f);
        @(posedge clk);
        case (k)
            0: done <= 1'b1;
            1: begin
                vs <= 1'b1;
                flg[1] <= f;
            end
            default: ls <= 1'b1;
        endcase
        @(posedge clk);
        {done, vs, ls} <= 3'b000;
        #1;
    endtask : pulse

    task automatic nxt();
        pulse(0, 1'b0);
        cyc(4);
    endtask : nxt

    task automatic trig(input logic [7:0] a, input logic [1:0] c);
        w(a, {6'h00, c});
        nxt();
        if (c != 2'b01) begin
            pulse(1, !c[0]);
            cyc(3);
        end
        check("no trig", starts, es);
        pulse(1, c[0]);
        cyc(3);
        es++;
        check("trig", starts, es);
    endtask : trig

    task automatic skip(input logic [7:0] a, input logic [2:0] n);
        w(a, {2'b00, n, 3'b000});
        pulse(0, 1'b0);
        for (int k = 1; k <= n; k++) begin
            cyc(3);
            check("skip", starts, es);
            pulse(1, 1'b0);
        end
        cyc(3);
        es++;
        check("skip", starts, es);
    endtask : skip

    // both sets get the same input configuration, then a task handover
    task automatic cfg(input logic v, input logic h, input logic [1:0] s);
        logic q;
        q = (s == 2'b00 || !mode);
        w(SCTS_ADDR_CFG_A, {v, h, s, q, 3'b000});
        w(SCTS_ADDR_CFG_B, {v, h, s, q, 3'b000});
        nxt();
    endtask : cfg

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("[ERR] watchdog expected end seen hang");
        results();
    end

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        cyc(4);
        es = 8'h01;
        check("starts", starts, es);
        foreach (ra[j]) rc("reset", ra[j], 8'h00);
        rc("marker", SCTS_ADDR_POWER, 8'h00);
        rc("status", 8'h8f, 8'h00);
        w(SCTS_ADDR_POWER, 8'hff);
        rc("marker", SCTS_ADDR_POWER, 8'h10);
        for (int i = 1; i < 9; i++) begin
            if (i != 3) begin
                @(posedge clk);
                flg <= (i == 8) ? 8'hf6 : 8'h01 << i;
                cyc(2);
                e = {flg[7:4], 1'b1, flg[2:1], flg[1]};
                rc("st", 8'h8f, e);
            end
        end
        w(8'h8f, 8'h00);
        rc("status ro", 8'h8f, e);
        rc("unmapped", 8'h55, 8'h00);
        @(posedge clk);
        flg <= 8'h00;
        foreach (ra[j]) w(ra[j], 8'(8'h5a + j * 8'h33));
        foreach (ra[j]) rc("set", ra[j], 8'(8'h5a + j * 8'h33));
        foreach (ra[j]) w(ra[j], 8'h00);
        $display("test registers done");
        trig(SCTS_ADDR_TASK_B, 2'b01);
        trig(SCTS_ADDR_TASK_A, 2'b10);
        trig(SCTS_ADDR_TASK_B, 2'b11);
        skip(SCTS_ADDR_TASK_A, 3'h2);
        skip(SCTS_ADDR_TASK_B, 3'h7);
        $display("test trigger done");
        w(SCTS_ADDR_TASK_A, 8'h04);
        w(SCTS_ADDR_TASK_B, 8'h00);
        for (int k = 0; k < 3; k++) begin
            nxt();
            es++;
            check("starts", starts, es);
            check("set", aset, 8'(k == 2));
        end
        $display("test repeat done");
        w(SCTS_ADDR_TASK_A, 8'hc0);
        nxt();
        check("bit7", b7, 8'h00);
        check("flag", tfl, 8'h00);
        w(SCTS_ADDR_TASK_A, 8'h00);
        cyc(2);
        check("bit7", b7, 8'h00);
        w(SCTS_ADDR_TASK_B, 8'h44);
        nxt();
        d = {7'h00, ofid};
        nxt();
        check("ofid toggle", ofid, 8'(!d[0]));
        w(SCTS_ADDR_TASK_B, 8'h00);
        nxt();
        check("bit7", b7, 8'h01);
        check("flag", tfl, 8'h01);
        for (int k = 1; k >= 0; k--) begin
            @(posedge clk);
            flg[1] <= k[0];
            cyc(2);
            check("ofid", ofid, 8'(k[0]));
            check("f", fb, 8'(k[0]));
        end
        $display("test field id done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            mode <= s[0];
            #1;
            cfg(1'b0, 1'b0, 2'(s));
            check("src", src, 8'(s));
            check("react", react, 8'(s[0]));
        end
        $display("test source done");
        cfg(1'b1, 1'b0, 2'b00);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            vi <= k[0];
            vg <= !k[0];
            cyc(3);
            check("v", vb, 8'(!k[0]));
            check("gate", gate, 8'(k[0]));
        end
        cfg(1'b0, 1'b1, 2'b00);
        pulse(2, 1'b0);
        @(posedge clk);
        vi <= 1'b0;
        cyc(4);
        check("v held", vb, 8'h01);
        pulse(2, 1'b0);
        cyc(2);
        check("v line", vb, 8'h00);
        $display("test sav bits done");
        d = starts;
        @(posedge clk);
        ce <= 1'b0;
        pulse(0, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        cyc(3);
        check("ce hold", starts, d);
        check("ce run", run, 8'h01);
        $display("test enable done");
        results();
    end
endmodule : scaler_task_status_control_test

`default_nettype wire
